// ===== power_loss_recovery_control.sv
// power-loss recovery controller of the board management controller
// assumes i_rst is applied whenever the standby rail comes back and the clock starts;
// the non-volatile store outside keeps o_nv_* across total power loss
`timescale 1ns/100ps
module power_loss_recovery_control #(
  parameter logic [power_loss_pkg::CNT_W-1:0] WINDOW_CYCLES =
    power_loss_pkg::CNT_W'(power_loss_pkg::WINDOW_CYCLES_DEF)
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_standby_ok,
  input  wire logic       i_system_on,
  input  wire logic       i_atx_supply,
  input  wire logic       i_policy_wr,
  input  wire logic [1:0] i_policy_sel,
  input  wire logic [1:0] i_nv_policy,
  input  wire logic       i_nv_last_on,
  input  wire logic       i_nv_pending,
  output logic            o_pwr_on_req,
  output logic            o_ac_loss,
  output logic            o_proper_off,
  output logic            o_window_active,
  output logic            o_nv_wr,
  output logic      [1:0] o_nv_policy,
  output logic            o_nv_last_on,
  output logic            o_nv_pending
);
  import power_loss_pkg::*;

  typedef struct packed {
    state_e           st;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       policy;
    logic             last_on;
    logic             pending;
    logic             ac_loss;
    logic             proper_off;
    logic             pwr_req;
    logic             nv_wr;
  } ctl_s;

  ctl_s r_ff;
  ctl_s nxt_r;

  logic [SYNC_W-1:0] sync_q;
  logic              standby_s;
  logic              sys_on_s;
  logic              atx_s;

  // pins cross into the clock domain before any decision looks at them
  input_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({i_atx_supply, i_system_on, i_standby_ok}),
    .o_sync    (sync_q)
  );

  assign standby_s = sync_q[SYNC_STANDBY];
  assign sys_on_s  = sync_q[SYNC_SYS_ON];
  assign atx_s     = sync_q[SYNC_ATX];

  // power-up decision from the stored policy and remembered state
  function automatic logic want_on(input logic [1:0] pol, input logic pend,
                                   input logic last);
    if (pol == POL_TURN_ON) begin
      want_on = 1'b1;
    end else if (pol == POL_LAST_STATE) begin
      want_on = pend & last;
    end else begin
      want_on = 1'b0;
    end
  endfunction

  // next-state logic of the whole controller
  always_comb begin
    nxt_r         = r_ff;
    nxt_r.pwr_req = 1'b0;
    case (r_ff.st)
      st_load: begin
        // the synchronisers are cleared by reset; deciding earlier would see no supply rail
        if (r_ff.cnt == CNT_W'(LOAD_CYCLES - 1)) begin
          // stored copy is taken after reset release, never under reset
          nxt_r.policy  = i_nv_policy;
          nxt_r.last_on = i_nv_last_on;
          nxt_r.pending = i_nv_pending;
          nxt_r.cnt     = '0;
          nxt_r.st      = st_decide;
        end else begin
          nxt_r.cnt = r_ff.cnt + CNT_W'(1);
        end
      end
      st_decide: begin
        nxt_r.ac_loss = r_ff.pending;
        if (atx_s) begin
          nxt_r.pwr_req = want_on(r_ff.policy, r_ff.pending, r_ff.last_on);
        end
        nxt_r.st = st_off;
      end
      st_on: begin
        // a standby loss seen no later than the main rail drop counts as an AC loss with last state on
        nxt_r.last_on    = 1'b1;
        nxt_r.pending    = 1'b1;
        nxt_r.ac_loss    = 1'b0;
        nxt_r.proper_off = 1'b0;
        if (!standby_s) begin
          // rail gone while running: an AC loss that keeps last state on;
          // limitation: a main rail that drops a clock ahead of standby reads as shutdown
          nxt_r.ac_loss = 1'b1;
          nxt_r.st      = st_loss;
        end else if (!sys_on_s) begin
          // remembering off at once avoids a false on after an early loss
          nxt_r.last_on = 1'b0;
          if (r_ff.policy == POL_LAST_STATE) begin
            nxt_r.cnt = '0;
            nxt_r.st  = st_window;
          end else begin
            nxt_r.pending = 1'b0;
            nxt_r.st      = st_off;
          end
        end
      end
      st_window: begin
        if (!standby_s) begin
          nxt_r.ac_loss = 1'b1;
          nxt_r.st      = st_loss;
        end else if (sys_on_s) begin
          nxt_r.st = st_on;
        end else if (r_ff.cnt == WINDOW_CYCLES - CNT_W'(1)) begin
          nxt_r.pending    = 1'b0;
          nxt_r.proper_off = 1'b1;
          nxt_r.st         = st_off;
        end else begin
          nxt_r.cnt = r_ff.cnt + CNT_W'(1);
        end
      end
      st_off: begin
        // standby watched here and in the window with no gap
        if (!standby_s) begin
          nxt_r.st = st_loss;
        end else if (sys_on_s) begin
          nxt_r.st = st_on;
        end
      end
      st_loss: begin
        // standby dipped but the controller survived: decide again on return
        if (standby_s) begin
          nxt_r.st = st_decide;
        end
      end
      default: begin
        nxt_r.st = st_load;
      end
    endcase
    if (i_policy_wr && r_ff.st != st_load) begin
      nxt_r.policy = i_policy_sel;
    end
    // store is written only on change to spare its endurance
    nxt_r.nv_wr = (r_ff.st != st_load) && (nxt_r.st != st_decide || r_ff.st != st_load) &&
                  ((nxt_r.policy != r_ff.policy) || (nxt_r.last_on != r_ff.last_on) ||
                   (nxt_r.pending != r_ff.pending));
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_ff            <= '0;
      r_ff.st         <= st_load;
      r_ff.policy     <= POL_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_pwr_on_req    = r_ff.pwr_req;
  assign o_ac_loss       = r_ff.ac_loss;
  assign o_proper_off    = r_ff.proper_off;
  assign o_window_active = (r_ff.st == st_window);
  assign o_nv_wr         = r_ff.nv_wr;
  assign o_nv_policy     = r_ff.policy;
  assign o_nv_last_on    = r_ff.last_on;
  assign o_nv_pending    = r_ff.pending;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  chk_window_start: assert property (
    r_ff.st == st_on && standby_s && !sys_on_s && r_ff.policy == POL_LAST_STATE && !i_policy_wr
    |=> r_ff.st == st_window && r_ff.cnt == '0)
    else $error("window did not start on shutdown under last-state policy");

  chk_no_window: assert property (
    r_ff.st == st_on && standby_s && !sys_on_s && r_ff.policy != POL_LAST_STATE
    |=> r_ff.st == st_off && !r_ff.pending)
    else $error("window used outside last-state policy");

  chk_proper_off: assert property (
    r_ff.st == st_window && standby_s && !sys_on_s && r_ff.cnt == WINDOW_CYCLES - CNT_W'(1)
    |=> !r_ff.pending && r_ff.proper_off && r_ff.st == st_off)
    else $error("full stable window not taken as proper switch-off");

  chk_ac_loss: assert property (
    r_ff.st == st_window && !standby_s
    |=> r_ff.ac_loss && r_ff.pending && r_ff.st == st_loss)
    else $error("standby loss inside window not flagged as AC loss");

  chk_run_loss: assert property (
    r_ff.st == st_on && !standby_s
    |=> r_ff.st == st_loss && r_ff.ac_loss && r_ff.last_on && r_ff.pending)
    else $error("loss while running not remembered as on");

  chk_turn_on: assert property (
    r_ff.st == st_decide && atx_s && r_ff.policy == POL_TURN_ON
    |=> o_pwr_on_req ##1 !o_pwr_on_req)
    else $error("turn-on policy gave no single power-on request");

  chk_remain_off: assert property (
    r_ff.st == st_decide && r_ff.policy == POL_REMAIN_OFF |=> !o_pwr_on_req)
    else $error("remain-off policy requested power-on");

  chk_last_state: assert property (
    r_ff.st == st_decide && atx_s && r_ff.policy == POL_LAST_STATE
    |=> o_pwr_on_req == ($past(r_ff.pending) && $past(r_ff.last_on)))
    else $error("last-state policy did not restore the remembered state");

  chk_no_rail: assert property (
    r_ff.st == st_decide && !atx_s |=> !o_pwr_on_req)
    else $error("policy acted on a supply without standby rail");

  chk_shutdown_off: assert property (
    r_ff.st == st_on && standby_s && !sys_on_s |=> !o_nv_last_on)
    else $error("shutdown left last state remembered as on");

  chk_nv_track: assert property (
    r_ff.st == st_on && sys_on_s && $stable(r_ff.policy) |=> o_nv_last_on && o_nv_pending)
    else $error("running system not remembered in the stored copy");

endmodule // power_loss_recovery_control

// ===== power_loss_pkg.sv
// constants, policy codes and controller states for the power-loss recovery logic
// assumes one 250 MHz clock that keeps running from the standby rail
package power_loss_pkg;

  // timing
  localparam longint unsigned CLK_HZ            = 64'd250_000_000;
  localparam longint unsigned WINDOW_S          = 64'd30;
  localparam longint unsigned WINDOW_CYCLES_DEF = WINDOW_S * CLK_HZ;
  localparam int              CNT_W             = 33;
  // cycles spent loading so the pin synchronisers hold real levels before deciding
  localparam int              LOAD_CYCLES       = 2;

  // policy codes; code 3 is unused and behaves as remain-off
  localparam logic [1:0] POL_TURN_ON    = 2'h0;
  localparam logic [1:0] POL_REMAIN_OFF = 2'h1;
  localparam logic [1:0] POL_LAST_STATE = 2'h2;
  localparam logic [1:0] POL_RST        = 2'h1;

  // synchroniser lanes
  localparam int SYNC_W       = 3;
  localparam int SYNC_STANDBY = 0;
  localparam int SYNC_SYS_ON  = 1;
  localparam int SYNC_ATX     = 2;

  typedef enum logic [2:0] {
    st_load,
    st_decide,
    st_off,
    st_on,
    st_window,
    st_loss
  } state_e;

endpackage

// ===== input_sync.sv
// two-stage synchroniser for the pin inputs of the recovery controller
// assumes inputs arrive asynchronously to i_sys_clk
`timescale 1ns/100ps
module input_sync (
  input  wire logic                             i_sys_clk,
  input  wire logic                             i_rst,
  input  wire logic [power_loss_pkg::SYNC_W-1:0] i_async,
  output logic      [power_loss_pkg::SYNC_W-1:0] o_sync
);
  import power_loss_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] q;
  } sync_s;

  sync_s r_ff;
  sync_s nxt_r;

  // meta is read only by the second stage
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.meta = i_async;
    nxt_r.q    = r_ff.meta;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_sync = r_ff.q;
endmodule // input_sync

// ===== atx_supply_model.sv
// behavioural model of an atx-style supply with a standby rail and main-power switch
// assumes the bench commands shutdown and mains cuts; the controller asks for power-on
`timescale 1ns/100ps
module atx_supply_model #(
  parameter int ON_LAT = 2
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_pwr_on_req,
  input  wire logic i_shutdown,
  input  wire logic i_ac_cut,
  input  wire logic i_has_standby,
  output logic      o_standby_ok,
  output logic      o_system_on,
  output logic      o_atx_supply
);
  int   wait_ff;
  logic on_ff;

  // main rail comes up ON_LAT cycles after a request; a cut or shutdown drops it at once
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_ac_cut || i_shutdown) begin
      on_ff   <= 1'b0;
      wait_ff <= 0;
    end else if (i_pwr_on_req && i_has_standby) begin
      wait_ff <= ON_LAT;
    end else if (wait_ff == 1) begin
      on_ff   <= 1'b1;
      wait_ff <= 0;
    end else if (wait_ff > 1) begin
      wait_ff <= wait_ff - 1;
    end
  end

  // without a standby rail neither standby nor supply is reported present; o_system_on follows on_ff alone
  assign o_standby_ok = i_has_standby && !i_ac_cut;
  assign o_system_on  = on_ff;
  assign o_atx_supply = i_has_standby;
endmodule // atx_supply_model

// ===== tb_top.sv
// self-checking bench for the power-loss recovery controller
// assumes a short window of 16 cycles and the supply model on the pin side
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import power_loss_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, shut = 1'b0, cut = 1'b0, has_sb = 1'b1;
  logic       pol_wr = 1'b0, last_on = 1'b0, pend = 1'b0;
  logic [1:0] pol_sel = 2'h0, nv_pol = 2'h0, nv_pol_o;
  logic       sb_ok, sys_on, atx, req, ac_loss, proper_off, win, nv_wr, nv_last, nv_pend;
  int         fail_count = 0, n_checks = 0, req_cnt = 0;

  always #2 clk = ~clk;
  // power-on requests are one-cycle pulses, so they are counted at each edge
  always @(posedge clk) if (req === 1'b1) req_cnt <= req_cnt + 1;

  power_loss_recovery_control #(.WINDOW_CYCLES(33'h10)) u_power_loss_recovery_control (
    .i_sys_clk(clk), .i_rst(rst), .i_standby_ok(sb_ok), .i_system_on(sys_on),
    .i_atx_supply(atx), .i_policy_wr(pol_wr), .i_policy_sel(pol_sel),
    .i_nv_policy(nv_pol), .i_nv_last_on(last_on), .i_nv_pending(pend),
    .o_pwr_on_req(req), .o_ac_loss(ac_loss), .o_proper_off(proper_off),
    .o_window_active(win), .o_nv_wr(nv_wr), .o_nv_policy(nv_pol_o),
    .o_nv_last_on(nv_last), .o_nv_pending(nv_pend));
  atx_supply_model u_atx_supply_model (
    .i_sys_clk(clk), .i_rst(rst), .i_pwr_on_req(req), .i_shutdown(shut),
    .i_ac_cut(cut), .i_has_standby(has_sb), .o_standby_ok(sb_ok),
    .o_system_on(sys_on), .o_atx_supply(atx));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // reset with a given stored image; the store is stable long before release
  task automatic boot(input logic [1:0] p, input logic l, input logic d, input logic a);
    @(negedge clk);
    rst = 1'b1; nv_pol = p; last_on = l; pend = d; has_sb = a; shut = 1'b0; cut = 1'b0;
    cyc(8);
    rst = 1'b0; req_cnt = 0;
    cyc(12);
  endtask
  task automatic t_policies;
    for (int p = 0; p < 4; p++) begin
      boot(p[1:0], 1'b1, 1'b1, 1'b1);
      `CHK(req_cnt, int'(p == 0 || p == 2));
    end
    boot(2'h2, 1'b0, 1'b1, 1'b1);
    `CHK(req_cnt, 0);
    boot(2'h0, 1'b1, 1'b1, 1'b0);
    `CHK(req_cnt, 0);
  endtask
  task automatic t_window;
    boot(2'h2, 1'b1, 1'b1, 1'b1);
    `CHK(nv_last, 1'b1);
    shut = 1'b1; cyc(1); shut = 1'b0; cyc(5);
    `CHK(win, 1'b1);
    `CHK(nv_last, 1'b0);
    cyc(20);
    `CHK(proper_off, 1'b1);
    `CHK(nv_pend, 1'b0);
    `CHK(win, 1'b0);
  endtask
  // mains cut well inside the window, then standby returns
  task automatic t_loss;
    boot(2'h2, 1'b1, 1'b1, 1'b1);
    shut = 1'b1; cyc(1); shut = 1'b0; cyc(6); cut = 1'b1; cyc(8);
    `CHK(ac_loss, 1'b1);
    `CHK(nv_pend, 1'b1);
    `CHK(proper_off, 1'b0);
    req_cnt = 0; cut = 1'b0; cyc(12);
    `CHK(req_cnt, 0);
  endtask
  // mains cut while running, then standby returns
  task automatic t_cut_on(input logic [1:0] p, input int exp);
    // remain-off is written while running, so the cut always finds the system on
    boot((p == 2'h1) ? 2'h0 : p, 1'b1, 1'b1, 1'b1);
    if (p == 2'h1) begin
      pol_wr = 1'b1; pol_sel = 2'h1; cyc(1); pol_wr = 1'b0; cyc(4);
    end
    req_cnt = 0; cut = 1'b1; cyc(8);
    `CHK(nv_last, 1'b1);
    cut = 1'b0; cyc(12);
    `CHK(req_cnt, exp);
  endtask
  task automatic t_no_window;
    boot(2'h0, 1'b1, 1'b1, 1'b1);
    shut = 1'b1; cyc(1); shut = 1'b0; cyc(6);
    `CHK(win, 1'b0);
    `CHK(nv_pend, 1'b0);
  endtask
  task automatic t_policy_wr;
    boot(2'h1, 1'b0, 1'b0, 1'b1);
    `CHK(nv_pol_o, 2'h1);
    pol_wr = 1'b1; pol_sel = 2'h2; cyc(1); pol_wr = 1'b0;
    `CHK(nv_wr, 1'b1);
    `CHK(nv_pol_o, 2'h2);
    cyc(1);
    `CHK(nv_wr, 1'b0);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    t_policies(); t_window(); t_loss();
    t_cut_on(2'h0, 1); t_cut_on(2'h1, 0); t_cut_on(2'h2, 1);
    t_no_window(); t_policy_wr();
    tally_and_finish();
  end
  // the sequence needs well under 2000 cycles
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_top
